// ===== src/tcb_top.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// sixteen-bit timer/counter with apb register access
module tcb_top (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [tcb_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   // external count source
   input  wire logic                        external_count_pin,
   // capture/compare unit
   input  wire logic [tcb_pkg::COUNT_W-1:0] compare_value,
   input  wire logic                        compare_special_mode,
   input  wire logic [tcb_pkg::COUNT_W-1:0] other_timer_count,
   output logic [tcb_pkg::COUNT_W-1:0]      capture_timebase,
   output logic                             capture_timebase_select,
   // converter trigger
   input  wire logic                        adc_enable,
   output logic                             adc_start,
   // interrupt
   output logic                             irq
);
   import tcb_pkg::*;

   // ----------
   // state
   // ----------
   tcb_ctrl_s           ctrl_ff;       // control register
   logic [COUNT_W-1:0]  count_ff;      // the counter
   logic [BYTE_W-1:0]   high_buf_ff;   // wide-mode high byte buffer
   logic [COUNT_W-1:0]  snap_ff;       // count seen at setup phase
   logic [DIV_W-1:0]    div_ff;        // fosc/4 divider
   logic [PRESC_W-1:0]  presc_ff;      // prescale counter
   logic [7:0]          irq_stat_ff;   // sticky flags
   logic [7:0]          irq_mask_ff;   // flag enables
   logic                irq_ff;        // interrupt line
   logic                pready_ff;     // bus answer
   logic [31:0]         prdata_ff;     // read data
   logic                pslverr_ff;    // unmapped address
   logic [COUNT_W-1:0]  timebase_ff;   // selected time base
   logic                adc_start_ff;  // converter start pulse
   logic                ext_tick;      // external edge pulse

   // ----------
   // external clock front end
   // ----------
   tcb_ext_clk u_ext_clk (
      .clk                    (clk),
      .sys_rst                (sys_rst),
      .external_count_pin     (external_count_pin),
      .clock_source_select    (ctrl_ff.clock_source_select),
      .ext_clock_sync_disable (ctrl_ff.ext_clock_sync_disable),
      .ext_tick               (ext_tick)
   );

   // ----------
   // apb decode
   // ----------
   wire setup_ph  = psel & ~penable;            // first cycle
   wire access_ok = psel & penable & pready_ff; // completing edge
   wire wr_done   = access_ok & pwrite;
   wire rd_done   = access_ok & ~pwrite;

   wire hit_ctrl  = (paddr == OFS_CTRL);
   wire hit_low   = (paddr == OFS_CNT_LOW);
   wire hit_high  = (paddr == OFS_CNT_HIGH);
   wire hit_stat  = (paddr == OFS_IRQ_STAT);
   wire hit_mask  = (paddr == OFS_IRQ_MASK);
   wire hit_any   = hit_ctrl | hit_low | hit_high | hit_stat | hit_mask;

   wire [BYTE_W-1:0] wbyte = pwdata[BYTE_W-1:0];

   wire wr_ctrl   = wr_done & hit_ctrl;
   wire wr_low    = wr_done & hit_low;
   wire wr_high   = wr_done & hit_high;
   wire wr_stat   = wr_done & hit_stat;
   wire wr_mask   = wr_done & hit_mask;
   wire rd_low    = rd_done & hit_low;

   wire wide_mode = ctrl_ff.wide_access_enable;

   // ----------
   // read mux, sampled at the setup edge
   // ----------
   // high byte in wide mode comes from the buffer latched by a low read
   wire [BYTE_W-1:0] rd_high_byte = wide_mode ? high_buf_ff : count_ff[COUNT_W-1:BYTE_W];
   wire [BYTE_W-1:0] rd_byte =
      hit_ctrl ? (ctrl_ff & CTRL_WMASK) :
      hit_low  ? count_ff[BYTE_W-1:0] :
      hit_high ? rd_high_byte :
      hit_stat ? irq_stat_ff :
      hit_mask ? irq_mask_ff : 8'h00;

   // ----------
   // apb answer: one access cycle, no wait states
   // ----------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
         snap_ff    <= COUNT_ZERO;
      end else begin
         pready_ff <= setup_ph;
         // capture answer and count snapshot while in setup
         if (setup_ph) begin
            prdata_ff  <= pwrite ? 32'h00000000 : {RDATA_PAD, rd_byte};
            pslverr_ff <= ~hit_any;
            snap_ff    <= count_ff;
         end
      end
   end

   // ----------
   // count clock: internal divider and prescaler
   // ----------
   wire div_tick  = (div_ff == DIV_LAST);
   // internal clock ignores the sync control bit entirely
   wire base_tick = ctrl_ff.clock_source_select ? ext_tick : div_tick;
   wire [PRESC_W-1:0] presc_last = tcb_presc_last(ctrl_ff.prescale_select);
   wire presc_wrap = (presc_ff == presc_last);
   wire count_wr   = wr_low | (wr_high & ~wide_mode);
   wire cnt_tick   = ctrl_ff.counter_run & base_tick & presc_wrap;

   // free-running fosc/4 divider
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_tick ? '0 : div_ff + 1'b1;
      end
   end

   // prescaler advances on base ticks, cleared by a count write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         presc_ff <= '0;
      end else if (count_wr) begin
         presc_ff <= '0;
      end else if (ctrl_ff.counter_run && base_tick) begin
         presc_ff <= presc_wrap ? '0 : presc_ff + 1'b1;
      end
   end

   // ----------
   // special event trigger from the compare match
   // ----------
   // unsynchronised external counting gives no reliable reset
   wire async_count = ctrl_ff.clock_source_select & ctrl_ff.ext_clock_sync_disable;
   wire period_hit  = (count_ff == compare_value);
   wire special_trig = compare_special_mode & ctrl_ff.capture_timebase_select
                       & period_hit & ~async_count;
   wire overflow    = cnt_tick & (count_ff == COUNT_MAX);

   // ----------
   // counter next value: write, then trigger, then increment
   // ----------
   logic [COUNT_W-1:0] nxt_count;
   always_comb begin
      nxt_count = count_ff;
      if (wr_low && wide_mode) begin
         nxt_count = {high_buf_ff, wbyte};
      end else if (wr_low) begin
         nxt_count = {count_ff[COUNT_W-1:BYTE_W], wbyte};
      end else if (wr_high && !wide_mode) begin
         nxt_count = {wbyte, count_ff[BYTE_W-1:0]};
      end else if (special_trig) begin
         nxt_count = COUNT_ZERO;
      end else if (cnt_tick) begin
         nxt_count = count_ff + 1'b1;
      end
   end

   // counter register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_ff <= COUNT_ZERO;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // ----------
   // wide-mode high byte buffer
   // ----------
   // a low read latches the high byte seen with it; a high write parks
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_buf_ff <= 8'h00;
      end else if (wide_mode && wr_high) begin
         high_buf_ff <= wbyte;
      end else if (wide_mode && rd_low) begin
         high_buf_ff <= snap_ff[COUNT_W-1:BYTE_W];
      end
   end

   // ----------
   // control register
   // ----------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= tcb_ctrl_s'(CTRL_RESET);
      end else if (wr_ctrl) begin
         ctrl_ff <= tcb_ctrl_s'(wbyte & CTRL_WMASK);
      end
   end

   // ----------
   // interrupt status, mask and line
   // ----------
   wire [7:0] stat_set = {7'h00, overflow};
   wire [7:0] stat_clr = wr_stat ? (wbyte & IRQ_WMASK) : 8'h00;
   // a new event wins over a clear in the same cycle
   wire [7:0] nxt_stat = (irq_stat_ff & ~stat_clr) | stat_set;
   wire [7:0] nxt_mask = wr_mask ? (wbyte & IRQ_WMASK) : irq_mask_ff;

   // sticky flags and enables
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_stat_ff <= IRQ_RESET;
         irq_mask_ff <= IRQ_RESET;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_stat;
         irq_mask_ff <= nxt_mask;
         irq_ff      <= |(nxt_stat & nxt_mask);
      end
   end

   // ----------
   // capture unit time base and converter start
   // ----------
   // time base follows this counter or the other timer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timebase_ff  <= COUNT_ZERO;
         adc_start_ff <= 1'b0;
      end else begin
         timebase_ff  <= ctrl_ff.capture_timebase_select ? nxt_count : other_timer_count;
         adc_start_ff <= special_trig & adc_enable;
      end
   end

   // ----------
   // outputs, all from flops
   // ----------
   assign pready                  = pready_ff;
   assign prdata                  = prdata_ff;
   assign pslverr                 = pslverr_ff;
   assign capture_timebase        = timebase_ff;
   assign capture_timebase_select = ctrl_ff.capture_timebase_select;
   assign adc_start               = adc_start_ff;
   assign irq                     = irq_ff;

endmodule

// ===== src/tcb_pkg.sv
// Overview of operation
// - sixteen-bit counter reached as two byte registers
// - wide mode buffers high byte for atomic access
// - two-bit prescale field divides count clock
// - control bit picks capture unit time base
// - external clock synchronised unless disable bit set
// - source select; external counts rises after falling
// - special event trigger clears the counter
// - same trigger starts converter when enabled
// - compare value acts as counter period
// - software write beats simultaneous trigger reset
package tcb_pkg;

   // ----------
   // register map (byte addresses on the apb bus)
   // ----------
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] OFS_CTRL      = 8'h00;   // counter control
   localparam logic [7:0] OFS_CNT_LOW   = 8'h04;   // count low byte
   localparam logic [7:0] OFS_CNT_HIGH  = 8'h08;   // count high byte
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;   // sticky event flags
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;   // interrupt enables

   // ----------
   // field layouts and reset values
   // ----------
   localparam int         COUNT_W       = 16;
   localparam int         BYTE_W        = 8;
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO   = 16'h0000;
   localparam logic [23:0] RDATA_PAD    = 24'h000000;  // upper read bits
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] CTRL_WMASK    = 8'hBF;   // bit 6 reads zero
   localparam logic [7:0] IRQ_RESET     = 8'h00;
   localparam logic [7:0] IRQ_WMASK     = 8'h01;   // only overflow bit
   localparam int         IRQ_OVF_BIT   = 0;

   // control register layout, msb first
   typedef struct packed {
      logic       wide_access_enable;       // bit 7
      logic       unused_bit6;              // bit 6, reads zero
      logic [1:0] prescale_select;          // bits 5-4
      logic       capture_timebase_select;  // bit 3
      logic       ext_clock_sync_disable;   // bit 2
      logic       clock_source_select;      // bit 1
      logic       counter_run;              // bit 0
   } tcb_ctrl_s;

   // ----------
   // clock rates
   // ----------
   localparam int         FOSC_DIV      = 4;       // instruction clock
   localparam int         DIV_W         = 2;
   localparam logic [1:0] DIV_LAST      = DIV_W'(FOSC_DIV - 1);
   localparam int         PRESC_W       = 3;

   // prescale code to terminal count of the prescale counter
   function automatic logic [2:0] tcb_presc_last(input logic [1:0] sel);
      logic [2:0] res;
      res = 3'h0;
      unique case (sel)
         2'h0:    res = 3'h0;  // 1:1
         2'h1:    res = 3'h1;  // 1:2
         2'h2:    res = 3'h3;  // 1:4
         2'h3:    res = 3'h7;  // 1:8
      endcase
      return res;
   endfunction

endpackage

// ===== src/tcb_ext_clk.sv
`timescale 1ns/1ps
// external count input: pin synchroniser, first-fall arming, edge ticks
module tcb_ext_clk (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // pin and controls
   input  wire logic external_count_pin,
   input  wire logic clock_source_select,
   input  wire logic ext_clock_sync_disable,
   // count edge pulse
   output logic      ext_tick
);
   import tcb_pkg::*;

   // ----------
   // arming states
   // ----------
   typedef enum logic [1:0] {
      ST_ARM = 2'b01,   // waiting for the first falling edge
      ST_RUN = 2'b10    // rising edges now count
   } tcb_arm_e;

   logic     sync1_ff;     // first stage, read only by second
   logic     sync2_ff;     // second stage
   logic     sync3_ff;     // third stage
   logic     level_ff;     // agreed pin level
   logic     rise_sync_ff; // clock-aligned rising edge
   tcb_arm_e arm_ff;       // arming state
   tcb_arm_e nxt_arm;

   // agreed level moves only when stages two and three match
   wire agree     = (sync2_ff == sync3_ff);
   wire nxt_level = agree ? sync3_ff : level_ff;
   wire rise_raw  = nxt_level & ~level_ff;
   wire fall_raw  = ~nxt_level & level_ff;

   // three-flop pin synchroniser and level filter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
         level_ff <= 1'b0;
      end else begin
         sync1_ff <= external_count_pin;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         level_ff <= nxt_level;
      end
   end

   // first fall arms counting; leaving external mode disarms
   always_comb begin
      nxt_arm = arm_ff;
      unique case (arm_ff)
         ST_ARM: if (clock_source_select && fall_raw) nxt_arm = ST_RUN;
         ST_RUN: if (!clock_source_select) nxt_arm = ST_ARM;
         default: nxt_arm = ST_ARM;  // illegal code recovers
      endcase
   end

   // state and aligned edge registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arm_ff       <= ST_ARM;
         rise_sync_ff <= 1'b0;
      end else begin
         arm_ff       <= nxt_arm;
         rise_sync_ff <= rise_raw;
      end
   end

   // synchronised path adds an aligning flop, otherwise raw edge
   wire armed = (arm_ff == ST_RUN) & clock_source_select;
   assign ext_tick = armed & (ext_clock_sync_disable ? rise_raw : rise_sync_ff);

endmodule

// ===== dv/tcb_partner.sv
`timescale 1ns/1ps
// far side: compare unit settings, other timer, external count source
module tcb_partner (
   // clock and bench requests
   input  wire logic                        clk,
   input  wire logic                        go,
   input  wire logic [3:0]                  n_rise,
   input  wire logic [4:0]                  half,
   input  wire logic [tcb_pkg::COUNT_W-1:0] cmp_req,
   input  wire logic                        mode_req,
   input  wire logic                        adc_req,
   // far-side outputs
   output logic                             external_count_pin,
   output logic [tcb_pkg::COUNT_W-1:0]      compare_value,
   output logic                             compare_special_mode,
   output logic [tcb_pkg::COUNT_W-1:0]      other_timer_count,
   output logic                             adc_enable,
   output logic                             busy
);
   import tcb_pkg::*;
   // ------------------------------------------------------------
   // pulse train on the pin, idle high, first edge a fall
   // ------------------------------------------------------------
   logic [4:0]  tog_ff = 5'h00;   // pin toggles left
   logic [4:0]  hp_ff  = 5'h00;   // cycles to next toggle
   logic        pin_ff = 1'b1;    // pin level
   logic [15:0] oth_ff = 16'h0000; // other timer
   assign external_count_pin = pin_ff;
   assign other_timer_count  = oth_ff;
   assign busy               = (tog_ff != 5'h00);
   // settings follow the bench one cycle later
   always @(posedge clk) begin
      oth_ff <= oth_ff + 16'h0003;
      compare_value <= cmp_req;
      compare_special_mode <= mode_req;
      adc_enable <= adc_req;
      if (go && !busy) begin
         tog_ff <= {n_rise, 1'b0};
         hp_ff <= half;
      end else if (busy && hp_ff != 5'h00) begin
         hp_ff <= hp_ff - 5'h01;
      end else if (busy) begin
         pin_ff <= ~pin_ff;
         tog_ff <= tog_ff - 5'h01;
         hp_ff <= half;
      end
   end
endmodule

// ===== dv/tcb_top_assertions.sv
`timescale 1ns/1ps
// port-level checks of the timer block
module tcb_checker (
   // clock and reset
   input wire logic                        clk,
   input wire logic                        sys_rst,
   // apb slave
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [tcb_pkg::ADDR_W-1:0]  paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic                        pready,
   input wire logic [31:0]                 prdata,
   input wire logic                        pslverr,
   // capture unit side
   input wire logic [tcb_pkg::COUNT_W-1:0] compare_value,
   input wire logic                        compare_special_mode,
   input wire logic [tcb_pkg::COUNT_W-1:0] other_timer_count,
   input wire logic [tcb_pkg::COUNT_W-1:0] capture_timebase,
   input wire logic                        capture_timebase_select,
   // converter and interrupt
   input wire logic                        adc_enable,
   input wire logic                        adc_start,
   input wire logic                        irq
);
   import tcb_pkg::*;
   // ------------------------------------------------------------
   // shadow of control and mask writes
   // ------------------------------------------------------------
   logic [7:0] ctrl_ff;   // last control write
   logic       mask_ff;   // last mask write
   logic       wr_ok;     // accepted write
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= CTRL_RESET;
         mask_ff <= 1'b0;
      end else if (wr_ok && paddr == OFS_CTRL) begin
         ctrl_ff <= pwdata[7:0] & CTRL_WMASK;
      end else if (wr_ok && paddr == OFS_IRQ_MASK) begin
         mask_ff <= pwdata[0];
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   unmapped_err_a: assert property (pready |-> pslverr == (paddr > OFS_IRQ_MASK || paddr[1:0] != 2'h0))
      else $error("error flag wrong for address");
   rdata_pad_a: assert property (pready |-> prdata[31:8] == RDATA_PAD)
      else $error("upper read bits not zero");
   sel_follow_a: assert property (!wr_ok && !$past(wr_ok) |-> capture_timebase_select == ctrl_ff[3])
      else $error("time base select differs from control");
   other_base_a: assert property (!capture_timebase_select && !$past(capture_timebase_select) && !$past(sys_rst)
      |-> capture_timebase == $past(other_timer_count))
      else $error("time base not the other timer");
   adc_cause_a: assert property (adc_start |-> $past(adc_enable) && $past(compare_special_mode) ##1 !adc_start)
      else $error("converter start without cause");
   period_a: assert property (capture_timebase_select && compare_special_mode && capture_timebase == compare_value
      && !(ctrl_ff[2] && ctrl_ff[1]) && !psel |-> ##[1:2] capture_timebase == COUNT_ZERO)
      else $error("count not cleared at period");
   ovf_irq_a: assert property (mask_ff && capture_timebase_select && capture_timebase == COUNT_ZERO
      && $past(capture_timebase) == COUNT_MAX && !psel && !$past(psel) |-> ##[0:2] irq)
      else $error("no interrupt after rollover");
   run_hold_a: assert property (!ctrl_ff[0] && !$past(ctrl_ff[0]) && capture_timebase_select
      && !compare_special_mode && !psel && !$past(psel) |=> $stable(capture_timebase))
      else $error("stopped count moved");
   cover property (adc_start);
   cover property (irq);
   cover property (pready && pslverr);
endmodule
bind tcb_top tcb_checker chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .compare_value(compare_value), .compare_special_mode(compare_special_mode),
   .other_timer_count(other_timer_count), .capture_timebase(capture_timebase),
   .capture_timebase_select(capture_timebase_select), .adc_enable(adc_enable), .adc_start(adc_start), .irq(irq));

// ===== dv/test_timer3_counter_block.sv
`timescale 1ns/1ps
module test_timer3_counter_block;
   import tcb_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, rd;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic        pready, pslverr, pin, mode, sel, adc_en, adc_start, irq, busy, err;
   logic        go = 1'b0, mode_req = 1'b0, adc_req = 1'b0;
   logic [3:0]  n_rise = 4'h1;
   logic [4:0]  half = 5'h08;
   logic [15:0] cmp_req = 16'h0000, cmp, other, tbase;
   int          mismatches = 0, checks_done = 0, adc_seen = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (adc_start === 1'b1) adc_seen++;
   tcb_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .external_count_pin(pin),
      .compare_value(cmp), .compare_special_mode(mode), .other_timer_count(other), .capture_timebase(tbase),
      .capture_timebase_select(sel), .adc_enable(adc_en), .adc_start(adc_start), .irq(irq));
   tcb_partner far_i (.clk(clk), .go(go), .n_rise(n_rise), .half(half), .cmp_req(cmp_req), .mode_req(mode_req),
      .adc_req(adc_req), .external_count_pin(pin), .compare_value(cmp), .compare_special_mode(mode),
      .other_timer_count(other), .adc_enable(adc_en), .busy(busy));
   // ------------------------------------------------------------
   // bus cycles, comparisons, expectations
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g, input logic [15:0] tol);
      checks_done++;
      if (!(g === e || ((g - e) <= tol) === 1'b1 || ((e - g) <= tol) === 1'b1)) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rd = prdata[7:0];
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rcount(output logic [15:0] v);
      apb(1'b0, OFS_CNT_LOW, 8'h00);
      v[7:0] = rd;
      apb(1'b0, OFS_CNT_HIGH, 8'h00);
      v[15:8] = rd;
   endtask
   task automatic setcount(input logic [15:0] v);
      apb(1'b1, OFS_CNT_LOW, v[7:0]);
      apb(1'b1, OFS_CNT_HIGH, v[15:8]);
   endtask
   function automatic logic [15:0] exp_ticks(input int cyc, input int ps);
      return 16'(cyc / (FOSC_DIV << ps));
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #400000;
      mismatches++;
      wrap_up();
   end
   initial begin
      logic [15:0] v, v2;
      int w;
      v = 16'($urandom(32'h594B790B));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, unmapped place, unimplemented bit
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 8'h00);
         chk("reset value", 16'h0000, {8'h00, rd}, 16'h0000);
      end
      apb(1'b0, 8'h14, 8'h00);
      chk("unmapped error", 16'h0001, {15'h0000, err}, 16'h0000);
      apb(1'b1, OFS_CTRL, 8'hFF);
      apb(1'b0, OFS_CTRL, 8'h00);
      chk("control", 16'h00BF, {8'h00, rd}, 16'h0000);
      chk("select", 16'h0001, {15'h0000, sel}, 16'h0000);
      $display("test registers done");
      // internal clock with every prescale code
      for (int ps = 0; ps < 4; ps++) begin
         w = (FOSC_DIV << ps) * (10 + $urandom % 20);
         apb(1'b1, OFS_CTRL, {2'b00, ps[1:0], 4'h8});
         setcount(16'h0000);
         apb(1'b1, OFS_CTRL, {2'b00, ps[1:0], 4'h9});
         repeat (w) @(posedge clk);
         apb(1'b1, OFS_CTRL, {2'b00, ps[1:0], 4'h8});
         rcount(v);
         chk("prescaled count", exp_ticks(w + 3, ps), v, 16'h0002);
         repeat (20) @(posedge clk);
         rcount(v2);
         chk("held count", v, v2, 16'h0000);
      end
      $display("test prescale done");
      // wide access buffering against direct access
      apb(1'b1, OFS_CTRL, 8'h88);
      apb(1'b1, OFS_CNT_HIGH, 8'h5A);
      rcount(v2);
      chk("buffered high", v, v2, 16'h0000);
      setcount(16'h1234);
      apb(1'b1, OFS_CNT_HIGH, 8'h12);
      apb(1'b1, OFS_CNT_LOW, 8'h34);
      rcount(v2);
      chk("wide write", 16'h1234, v2, 16'h0000);
      apb(1'b1, OFS_CTRL, 8'h08);
      apb(1'b1, OFS_CNT_HIGH, 8'h77);
      rcount(v2);
      chk("narrow write", 16'h7734, v2, 16'h0000);
      chk("time base", 16'h7734, tbase, 16'h0000);
      $display("test wide access done");
      // rollover flag, masked then unmasked
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, OFS_IRQ_MASK, 8'(m));
         setcount(16'hFFF0);
         apb(1'b1, OFS_CTRL, 8'h09);
         repeat (100) @(posedge clk);
         chk("irq level", 16'(m), {15'h0000, irq}, 16'h0000);
         apb(1'b0, OFS_IRQ_STAT, 8'h00);
         chk("overflow flag", 16'h0001, {8'h00, rd}, 16'h0000);
         apb(1'b1, OFS_IRQ_STAT, 8'h01);
         apb(1'b0, OFS_IRQ_STAT, 8'h00);
         chk("flag cleared", 16'h0000, {7'h00, irq, rd}, 16'h0000);
         apb(1'b1, OFS_CTRL, 8'h08);
      end
      $display("test overflow done");
      // special event trigger as period, with and without converter
      setcount(16'h0000);
      for (int a = 0; a < 2; a++) begin
         cmp_req <= 16'(20 + $urandom % 40);
         adc_req <= a[0];
         mode_req <= 1'b1;
         repeat (3) @(posedge clk);
         adc_seen = 0;
         apb(1'b1, OFS_CTRL, 8'h09);
         repeat (400) @(posedge clk);
         apb(1'b1, OFS_CTRL, 8'h08);
         mode_req <= 1'b0;
         rcount(v);
         chk("count within period", 16'h0001, {15'h0000, v <= cmp_req}, 16'h0000);
         chk("converter start", 16'(a), {15'h0000, adc_seen > 0}, 16'h0000);
      end
      $display("test trigger done");
      // external pin, synchronised and not
      for (int s = 0; s < 2; s++) begin
         setcount(16'h0000);
         apb(1'b1, OFS_CTRL, {4'h0, 1'b1, s[0], 2'b11});
         n_rise <= 4'(1 + $urandom % 8);
         half <= 5'(6 + $urandom % 20);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         @(posedge clk);
         w = 0;
         while (busy !== 1'b0 && w < 2000) begin
            @(posedge clk);
            w++;
         end
         repeat (10) @(posedge clk);
         rcount(v);
         chk("external count", {12'h000, n_rise}, v, 16'h0000);
      end
      $display("test external clock done");
      wrap_up();
   end
endmodule
